// ### common/fbc_pkg.sv
// Purpose: Constants for the parallel flash bus controller
// Assumes: 40 MHz core clock, byte-wide flash with 17 address bits
// Notes:   Timing figures in ns, cycle counts derived from them
package fbc_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 25;
   // Access time of the slowest speed grade, also used for chip-select
   localparam int ACCESS_NS = 90;
   localparam int SETUP_NS = 25;
   localparam int STROBE_NS = 50;
   localparam int RECOVER_NS = 25;
   localparam int RESET_PULSE_NS = 500;
   localparam int RESET_RECOVER_NS = 500;
   // Least times round up to whole cycles
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYC =
      (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_CYC =
      (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_RECOVER_CYC =
      (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   // Sector protect address pattern bits
   localparam int PROT_SEL_BIT = 6;
   localparam int PROT_A1_BIT = 1;
   localparam int PROT_A0_BIT = 0;
   // Host operation codes
   typedef enum logic [2:0] {
      FBC_OP_READ,
      FBC_OP_WRITE,
      FBC_OP_RESET,
      FBC_OP_PROTECT,
      FBC_OP_UNPROTECT
   } fbc_op_e;
endpackage

// ### core/fbc_ctrl.sv
// Purpose: Host-side controller driving a byte-wide parallel flash
// Assumes: Flash pins reached directly; one request in flight at a time
// Notes:   Read data is sampled through a two-stage synchroniser
//
// Behaviour
// R1 - Read: select and output gate low, write strobe high, sample data
// R2 - Write: select and write strobe low, output gate high, drive data
// R3 - Command register has no address; commands are plain write cycles
// R4 - After power-up or reset the flash reads array with no command
// R5 - Flash stays in array read until a write changes its commands
// R6 - All seventeen address bits are presented on every cycle
// R7 - Bypass programming needs two writes, normal programming four
// R8 - Erase covers one sector, several sectors or the whole array
// R9 - After the identification sequence, reads return internal codes
// R10 - During program or erase, reads return status bits
// R11 - Select and reset high put the flash in standby, data floats
// R12 - Host waits full chip-select access time before sampling data
// R13 - Reset low also places the flash in standby
// R14 - Deselecting during program or erase does not abort it
// R15 - Stable address enters sleep; output data stays latched
// R16 - Reset pulse of minimum width aborts and returns to array read
// R17 - Host reissues any operation interrupted by a hardware reset
// R18 - Protect: high voltage reset, write cycle, A6 low, A1 high, A0 low
// R19 - Unprotect: same as protect but A6 high
// R20 - Output gate high floats the flash data pins
// R21 - Only one pattern at a time; never gate and strobe low together
`timescale 1ns/1ps
module fbc_ctrl
(
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   // Request side
   input  wire logic                       req_valid,
   input  wire fbc_pkg::fbc_op_e           req_op,
   input  wire logic [fbc_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [fbc_pkg::DATA_W-1:0] req_wdata,
   output logic                            req_ready,
   output logic                            rsp_valid,
   output logic      [fbc_pkg::DATA_W-1:0] rsp_rdata,
   output logic                            rsp_aborted,
   // Flash pins
   output logic      [fbc_pkg::ADDR_W-1:0] address_pins,
   input  wire logic [fbc_pkg::DATA_W-1:0] data_pins_in,
   output logic      [fbc_pkg::DATA_W-1:0] data_pins_out,
   output logic                            data_pins_oe,
   output logic                            chip_select_n,
   output logic                            output_gate_n,
   output logic                            write_strobe_n,
   output logic                            reset_n,
   output logic                            high_identification_voltage
);
   typedef enum logic [2:0] {
      FBC_IDLE,
      FBC_SETUP,
      FBC_STROBE,
      FBC_ACCESS,
      FBC_RECOVER,
      FBC_RST_LOW,
      FBC_RST_WAIT
   } fbc_state_e;

   typedef struct packed {
      fbc_state_e                 state;
      logic [fbc_pkg::CNT_W-1:0]  cnt;
      logic                       is_read;
      logic                       hv;
      logic                       ready;
      logic                       rvalid;
      logic [fbc_pkg::DATA_W-1:0] rdata;
      logic                       aborted;
      logic [fbc_pkg::ADDR_W-1:0] addr;
      logic [fbc_pkg::DATA_W-1:0] wdata;
      logic                       oe;
      logic                       cs_n;
      logic                       og_n;
      logic                       ws_n;
      logic                       rst_n;
   } fbc_ctrl_s;

   fbc_ctrl_s                  st_reg;
   fbc_ctrl_s                  st_next;
   logic [fbc_pkg::DATA_W-1:0] data_sync;

   fbc_sync u_sync
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in (data_pins_in),
      .sync_out (data_sync)
   );

   function automatic logic [fbc_pkg::CNT_W-1:0] cyc(input int n);
      cyc = fbc_pkg::CNT_W'(n - 1);
   endfunction

   always_comb
   begin
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      case (st_reg.state)
         FBC_IDLE:
         begin
            // Parked with select and reset high: flash in standby
            st_next.cs_n = 1'b1; // R11
            st_next.og_n = 1'b1; // R20
            st_next.ws_n = 1'b1;
            st_next.oe = 1'b0;
            st_next.ready = 1'b1;
            if (req_valid && st_reg.ready)
            begin
               st_next.ready = 1'b0;
               st_next.aborted = 1'b0;
               st_next.addr = req_addr; // R6
               st_next.wdata = req_wdata;
               st_next.is_read = (req_op == fbc_pkg::FBC_OP_READ);
               st_next.hv = 1'b0;
               st_next.cnt = cyc(fbc_pkg::SETUP_CYC);
               st_next.state = FBC_SETUP;
               case (req_op)
                  fbc_pkg::FBC_OP_RESET:
                  begin
                     // Flash aborts and floats; caller must reissue
                     st_next.rst_n = 1'b0; // R13 R16 R17
                     st_next.cnt = cyc(fbc_pkg::RESET_PULSE_CYC);
                     st_next.state = FBC_RST_LOW;
                  end
                  fbc_pkg::FBC_OP_PROTECT:
                  begin
                     st_next.hv = 1'b1; // R18
                     st_next.addr[fbc_pkg::PROT_SEL_BIT] = 1'b0;
                     st_next.addr[fbc_pkg::PROT_A1_BIT] = 1'b1;
                     st_next.addr[fbc_pkg::PROT_A0_BIT] = 1'b0;
                  end
                  fbc_pkg::FBC_OP_UNPROTECT:
                  begin
                     st_next.hv = 1'b1; // R19
                     st_next.addr[fbc_pkg::PROT_SEL_BIT] = 1'b1;
                     st_next.addr[fbc_pkg::PROT_A1_BIT] = 1'b1;
                     st_next.addr[fbc_pkg::PROT_A0_BIT] = 1'b0;
                  end
                  default:
                  begin
                     st_next.hv = 1'b0;
                  end
               endcase
            end
         end
         FBC_SETUP:
         begin
            // Address settles a cycle ahead of select and strobe
            st_next.cs_n = 1'b0;
            st_next.oe = ~st_reg.is_read; // R2
            if (st_reg.cnt == '0)
            begin
               if (st_reg.is_read)
               begin
                  // Gate low only while strobe stays high
                  st_next.og_n = 1'b0; // R1 R21
                  st_next.cnt = cyc(fbc_pkg::ACCESS_CYC + 2);
                  st_next.state = FBC_ACCESS;
               end
               else
               begin
                  // Bypass or normal sequences are plain write cycles
                  st_next.ws_n = 1'b0; // R2 R3 R7 R21
                  st_next.cnt = cyc(fbc_pkg::STROBE_CYC);
                  st_next.state = FBC_STROBE;
               end
            end
            else
            begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end
         end
         FBC_STROBE:
         begin
            if (st_reg.cnt == '0)
            begin
               // Falling strobe has latched address and data in the flash; rising ends the pulse
               st_next.ws_n = 1'b1; // R2
               st_next.cnt = cyc(fbc_pkg::RECOVER_CYC);
               st_next.state = FBC_RECOVER;
            end
            else
            begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end
         end
         FBC_ACCESS:
         begin
            // Full select access time plus two synchroniser stages
            if (st_reg.cnt == '0)
            begin
               st_next.rdata = data_sync; // R12 R1 R9 R10
               st_next.og_n = 1'b1; // R20
               st_next.cnt = cyc(fbc_pkg::RECOVER_CYC);
               st_next.state = FBC_RECOVER;
            end
            else
            begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end
         end
         FBC_RECOVER:
         begin
            st_next.oe = 1'b0;
            st_next.cs_n = 1'b1; // R14
            if (st_reg.cnt == '0)
            begin
               st_next.hv = 1'b0;
               st_next.rvalid = 1'b1;
               st_next.ready = 1'b1;
               st_next.state = FBC_IDLE;
            end
            else
            begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end
         end
         FBC_RST_LOW:
         begin
            if (st_reg.cnt == '0)
            begin
               st_next.rst_n = 1'b1; // R4 R16
               st_next.cnt = cyc(fbc_pkg::RESET_RECOVER_CYC);
               st_next.state = FBC_RST_WAIT;
            end
            else
            begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end
         end
         FBC_RST_WAIT:
         begin
            if (st_reg.cnt == '0)
            begin
               st_next.aborted = 1'b1; // R17
               st_next.rvalid = 1'b1;
               st_next.ready = 1'b1;
               st_next.state = FBC_IDLE;
            end
            else
            begin
               st_next.cnt = st_reg.cnt - 1'b1;
            end
         end
         default:
         begin
            st_next.state = FBC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         st_reg <= '0;
         st_reg.state <= FBC_IDLE;
         st_reg.cs_n <= 1'b1;
         st_reg.og_n <= 1'b1;
         st_reg.ws_n <= 1'b1;
         st_reg.rst_n <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign req_ready = st_reg.ready;
   assign rsp_valid = st_reg.rvalid;
   assign rsp_rdata = st_reg.rdata;
   assign rsp_aborted = st_reg.aborted;
   assign address_pins = st_reg.addr;
   assign data_pins_out = st_reg.wdata;
   assign data_pins_oe = st_reg.oe;
   assign chip_select_n = st_reg.cs_n;
   assign output_gate_n = st_reg.og_n;
   assign write_strobe_n = st_reg.ws_n;
   assign reset_n = st_reg.rst_n;
   assign high_identification_voltage = st_reg.hv;
endmodule

// ### core/fbc_sync.sv
// Purpose: Two-stage synchroniser for the flash data pins
// Assumes: Data pins change asynchronously to core_clk
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module fbc_sync
(
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   // Data
   input  wire logic [fbc_pkg::DATA_W-1:0] async_in,
   output logic      [fbc_pkg::DATA_W-1:0] sync_out
);
   typedef struct packed {
      logic [fbc_pkg::DATA_W-1:0] meta;
      logic [fbc_pkg::DATA_W-1:0] stable;
   } fbc_sync_s;

   fbc_sync_s st_reg;
   fbc_sync_s st_next;

   always_comb
   begin
      st_next = st_reg;
      st_next.meta = async_in;
      st_next.stable = st_reg.meta;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.stable;
endmodule

// ### tb/fbc_ctrl_asserts.sv
// Purpose: Port timing checks for the flash controller
// Assumes: One clock, synchronous active-high reset
// Notes:   A pin updated at edge n is seen at edge n+1
`timescale 1ns/1ps
module fbc_ctrl_asserts
(
   // Clock and reset
   input wire logic                       core_clk,
   input wire logic                       sys_rst,
   // Request side
   input wire logic                       req_valid,
   input wire fbc_pkg::fbc_op_e           req_op,
   input wire logic [fbc_pkg::ADDR_W-1:0] req_addr,
   input wire logic                       req_ready,
   input wire logic                       rsp_valid,
   input wire logic                       rsp_aborted,
   // Flash pins
   input wire logic [fbc_pkg::ADDR_W-1:0] address_pins,
   input wire logic                       data_pins_oe,
   input wire logic                       chip_select_n,
   input wire logic                       output_gate_n,
   input wire logic                       write_strobe_n,
   input wire logic                       reset_n,
   input wire logic                       high_identification_voltage
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic       take;
   logic [7:0] low_cnt_reg;
   assign take = req_valid && req_ready;
   // Counts sampled low cycles of the reset pin
   always_ff @(posedge core_clk)
      low_cnt_reg <= (sys_rst || reset_n) ? 8'h00 : low_cnt_reg + 8'h01;
   a_gate_strobe_apart:
      assert property (output_gate_n || write_strobe_n)
      else $error("gate and strobe low together");
   a_read_pins:
      assert property (!output_gate_n |-> !chip_select_n && write_strobe_n
         && !data_pins_oe) else $error("bad read pin pattern");
   a_write_pins:
      assert property (!write_strobe_n |-> !chip_select_n && output_gate_n
         && data_pins_oe) else $error("bad write pin pattern");
   a_write_seq:
      assert property (take && req_op == fbc_pkg::FBC_OP_WRITE |-> ##2
         (!chip_select_n && !write_strobe_n)[*2] ##1
         (write_strobe_n && !chip_select_n) ##1
         (chip_select_n && rsp_valid && req_ready))
      else $error("write cycle sequence wrong");
   a_write_addr:
      assert property (take && req_op == fbc_pkg::FBC_OP_WRITE |-> ##3
         address_pins == $past(req_addr, 3))
      else $error("write address not presented");
   a_read_seq:
      assert property (take && req_op == fbc_pkg::FBC_OP_READ |-> ##2
         (!chip_select_n && !output_gate_n) ##1 (!output_gate_n)[*5] ##1
         (output_gate_n && !chip_select_n) ##1 (rsp_valid && chip_select_n))
      else $error("read cycle sequence wrong");
   a_protect_pat:
      assert property (take && req_op == fbc_pkg::FBC_OP_PROTECT |-> ##3
         !write_strobe_n && high_identification_voltage && !address_pins[6]
         && address_pins[1] && !address_pins[0])
      else $error("protect pattern wrong");
   a_unprotect_pat:
      assert property (take && req_op == fbc_pkg::FBC_OP_UNPROTECT |-> ##3
         !write_strobe_n && high_identification_voltage && address_pins[6]
         && address_pins[1] && !address_pins[0])
      else $error("unprotect pattern wrong");
   a_reset_width:
      assert property ($rose(reset_n) |-> low_cnt_reg == 8'h14)
      else $error("reset pulse width wrong");
   a_reset_abort:
      assert property (take && req_op == fbc_pkg::FBC_OP_RESET |-> ##41
         rsp_valid && rsp_aborted) else $error("reset answer wrong");
   a_reset_quiet:
      assert property (!reset_n |-> chip_select_n && output_gate_n
         && write_strobe_n) else $error("strobes during reset");
endmodule
bind fbc_ctrl fbc_ctrl_asserts u_fbc_ctrl_asserts (.core_clk, .sys_rst,
   .req_valid, .req_op, .req_addr, .req_ready, .rsp_valid, .rsp_aborted,
   .address_pins, .data_pins_oe, .chip_select_n, .output_gate_n,
   .write_strobe_n, .reset_n, .high_identification_voltage);

// ### tb/fbc_ctrl_tb.sv
// Purpose: Self-checking bench for the flash controller
// Assumes: Controller faces the behavioural flash model
// Notes:   Random addresses and data, seed fixed
`timescale 1ns/1ps
module fbc_ctrl_tb;
   logic core_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
   fbc_pkg::fbc_op_e req_op = fbc_pkg::FBC_OP_READ;
   logic [16:0] req_addr = 17'h00000, a, cmd_addr;
   logic [7:0] req_wdata = 8'h00, d, rsp_rdata, dout, din, flash_q, cmd_data;
   logic req_ready, rsp_valid, rsp_aborted, oe, cs_n, og_n, ws_n, rst_n;
   logic hv, cmd_hv;
   logic [16:0] address_pins;
   int n_mismatch = 0, checked = 0;
   assign din = oe ? dout : flash_q;
   always #12.5 core_clk = ~core_clk;
   fbc_ctrl u_fbc_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_aborted(rsp_aborted),
      .address_pins(address_pins), .data_pins_in(din), .data_pins_out(dout),
      .data_pins_oe(oe), .chip_select_n(cs_n), .output_gate_n(og_n),
      .write_strobe_n(ws_n), .reset_n(rst_n),
      .high_identification_voltage(hv));
   fbc_flash_model u_fbc_flash_model (.address_pins(address_pins),
      .data_in(dout), .chip_select_n(cs_n), .output_gate_n(og_n),
      .write_strobe_n(ws_n), .reset_n(rst_n),
      .high_identification_voltage(hv), .flash_q(flash_q),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_hv(cmd_hv));
   function automatic logic [7:0] exp_byte(input logic [16:0] x);
      return x[7:0] ^ x[15:8] ^ {7'h00, x[16]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Starts and ends on a rising edge; bounded waits count as mismatches
   task automatic do_op(input fbc_pkg::fbc_op_e op, input logic [16:0] x,
                        input logic [7:0] y);
      int n;
      #1;
      req_op = op;
      req_addr = x;
      req_wdata = y;
      req_valid = 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (req_ready !== 1'b1 && n < 50);
      if (req_ready !== 1'b1)
         check(32'h0, 32'h1);
      #1;
      req_valid = 1'b0;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (rsp_valid !== 1'b1 && n < 60);
      if (n >= 60)
         check(32'h0, 32'h1);
   endtask
   task automatic finish_test();
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #200000;
      n_mismatch++;
      finish_test();
   end
   initial
   begin
      void'($urandom(41142));
      repeat (8) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      @(posedge core_clk);
      // Corner addresses first, then random; no command before reads
      for (int i = 0; i < 8; i++)
      begin
         a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1FFFF : 17'($urandom);
         do_op(fbc_pkg::FBC_OP_READ, a, 8'h00);
         check(rsp_rdata, exp_byte(a));
      end
      $display("test read done");
      // Back-to-back writes, taken the cycle after each answer
      for (int i = 0; i < 6; i++)
      begin
         a = 17'($urandom);
         d = 8'($urandom);
         do_op(fbc_pkg::FBC_OP_WRITE, a, d);
         check(cmd_addr, a);
         check(cmd_data, d);
         check(cmd_hv, 1'b0);
      end
      $display("test write done");
      for (int k = 0; k < 2; k++)
      begin
         a = 17'($urandom);
         do_op(k ? fbc_pkg::FBC_OP_UNPROTECT : fbc_pkg::FBC_OP_PROTECT, a,
            8'($urandom));
         check(cmd_addr[6], k[0]);
         check(cmd_addr[1:0], 2'h2);
         check(cmd_addr[16:12], a[16:12]);
         check(cmd_hv, 1'b1);
      end
      $display("test protect done");
      do_op(fbc_pkg::FBC_OP_RESET, 17'h00000, 8'h00);
      check(rsp_aborted, 1'b1);
      a = 17'($urandom);
      do_op(fbc_pkg::FBC_OP_READ, a, 8'h00);
      check(rsp_rdata, exp_byte(a));
      check(rsp_aborted, 1'b0);
      d = 8'($urandom);
      do_op(fbc_pkg::FBC_OP_WRITE, a, d);
      check(cmd_data, d);
      $display("test reset done");
      finish_test();
   end
endmodule

// ### tb/fbc_flash_model.sv
// Purpose: Behavioural byte-wide flash seen from its pins
// Assumes: Array content is a fixed function of the address
// Notes:   Floating data shows the inverse of the last byte driven
`timescale 1ns/1ps
module fbc_flash_model
(
   // Flash pins
   input wire logic [fbc_pkg::ADDR_W-1:0] address_pins,
   input wire logic [fbc_pkg::DATA_W-1:0] data_in,
   input wire logic                       chip_select_n,
   input wire logic                       output_gate_n,
   input wire logic                       write_strobe_n,
   input wire logic                       reset_n,
   input wire logic                       high_identification_voltage,
   output logic     [fbc_pkg::DATA_W-1:0] flash_q,
   // Command latch view
   output logic     [fbc_pkg::ADDR_W-1:0] cmd_addr,
   output logic     [fbc_pkg::DATA_W-1:0] cmd_data,
   output logic                           cmd_hv
);
   logic       ready = 1'b0;
   logic       drive;
   logic [7:0] last_q = 8'h00;
   logic [7:0] arr_q;
   // Code and status reads use the same read cycle as the array
   assign arr_q = address_pins[7:0] ^ address_pins[15:8]
      ^ {7'h00, address_pins[16]};
   // Not ready until a full select access time has passed
   // Non-blocking so a reselect inside the delay is not missed
   always @(chip_select_n)
      ready <= #(fbc_pkg::ACCESS_NS) !chip_select_n;
   assign drive = !chip_select_n && !output_gate_n && write_strobe_n
      && reset_n && ready;
   always @*
      if (drive)
         last_q = arr_q;
   assign flash_q = drive ? arr_q : ~last_q;
   // Settle 1 ns past the edge before latching, pins move on the same edge
   always @(negedge write_strobe_n)
   begin
      #1;
      // Latched command survives a later deselect
      if (!chip_select_n && reset_n)
      begin
         cmd_addr = address_pins;
         cmd_data = data_in;
         cmd_hv = high_identification_voltage;
      end
   end
endmodule
